// *** bench/axs_chk.sv ***
`timescale 1ns/1ps
module axs_chk
   import axs_pkg::*;
#(
   parameter int KERNEL_CYCLES = KERNEL_CYC
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // sample stream
   input wire logic sample_valid,
   input wire logic [DW-1:0] sample_data
);
   int gap;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // zero until the first sample, so the start-up interval is not judged
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gap <= 0;
      end else if (sample_valid) begin
         gap <= 1;
      end else if (gap != 0) begin
         gap <= gap + 1;
      end
   end
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("pready held longer than one cycle");
   a_ready_wait: assert property (psel && penable && !pready |=> pready)
      else $error("pready missing after one wait cycle");
   a_ready_cause: assert property (pready |-> psel && penable && $past(penable))
      else $error("pready without a waited access");
   a_err_ready: assert property (pslverr |-> pready)
      else $error("pslverr outside the ready cycle");
   a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
      else $error("read data not zero outside ready");
   a_io_undef: assert property (pready && !pwrite && paddr[7:5] == 3'h2 |->
      (prdata & 32'hffff_e700) == 32'h0) else $error("io word spare bit set");
   a_mot_undef: assert property (pready && !pwrite && paddr[7:5] == 3'h3 |->
      (prdata & 32'heff0_7380) == 32'h0) else $error("motion word spare bit set");
   a_valid_pulse: assert property (sample_valid |=> !sample_valid)
      else $error("sample valid longer than one cycle");
   a_valid_period: assert property (sample_valid && gap != 0 |-> gap % KERNEL_CYCLES == 0)
      else $error("sample spacing off the kernel period");
   a_data_hold: assert property (!sample_valid |-> $stable(sample_data))
      else $error("sample data changed without valid");
endmodule : axs_chk

// *** bench/axs_drive_model.sv ***
`timescale 1ns/1ps
module axs_drive_model
   import axs_pkg::*;
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // levels asked for by the bench
   input wire axs_pin_s [NAX-1:0] want,
   // machine pins
   output axs_pin_s [NAX-1:0] pins
);
   // one cycle of cable lag, so the synchroniser sees a late change
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pins <= '0;
      end else begin
         pins <= want;
      end
   end
endmodule : axs_drive_model

// *** bench/axs_sampler_bench.sv ***
`timescale 1ns/1ps
module axs_sampler_bench
   import axs_pkg::*;
;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic ce = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   axs_pin_s [NAX-1:0] want = '0;
   axs_pin_s [NAX-1:0] pins;
   axs_kin_s [NAX-1:0] kin = '0;
   axs_qty_s [NAX-1:0] qty = '0;
   logic [1:0][DW-1:0] path_vel = '0;
   logic [1:0][DW-1:0] path_acc = '0;
   logic [1:0][DW-1:0] unit_vel = '0;
   logic sample_valid;
   logic [DW-1:0] sample_data;
   logic [31:0] rd;
   logic er;
   int bad_count = 0;
   int n_checks = 0;
   axs_sampler #(.KERNEL_CYCLES(50)) i_axs_sampler (.pclk(pclk), .presetn(presetn), .ce(ce),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .pins(pins), .kin(kin),
      .qty(qty), .path_vel(path_vel), .path_acc(path_acc), .unit_vel(unit_vel),
      .sample_valid(sample_valid), .sample_data(sample_data));
   axs_drive_model i_axs_drive_model (.pclk(pclk), .presetn(presetn), .want(want),
      .pins(pins));
   always #10 pclk = ~pclk;
   task automatic chk(input string w, input logic [63:0] seen, input logic [63:0] e);
      n_checks++;
      if (seen !== e) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", w, e, seen);
      end
   endtask : chk
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic rchk(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk("register", rd, e);
   endtask : rchk
   task automatic pulse(input axs_kin_s v);
      @(posedge pclk);
      kin[4] <= v;
      @(posedge pclk);
      kin[4] <= '0;
   endtask : pulse
   // the first sample after a source change may still carry the old source
   task automatic smp(input logic [4:0] s, input logic [2:0] x, input logic [63:0] e);
      apb(1'b1, OFS_CTRL, {17'h0, x, 3'h0, s, 3'h0, 1'b1});
      repeat (2) begin
         do begin
            @(posedge pclk);
         end while (sample_valid !== 1'b1);
      end
      chk("sample", sample_data, e);
      rchk(OFS_SLO, e[31:0]);
      rchk(OFS_SHI, e[63:32]);
   endtask : smp
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : report_and_stop
   initial begin
      repeat (30000) @(posedge pclk);
      bad_count++;
      report_and_stop();
   end
   initial begin
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      rchk(OFS_LOOP, 32'h0000_30d4);
      apb(1'b1, OFS_LOOP, 32'h0000_000a);
      rchk(OFS_LOOP, 32'h0000_000a);
      rchk(OFS_MOT + 8'h10, 32'h0000_0020);
      apb(1'b1, OFS_MOT + 8'h10, 32'hffff_ffff);
      rchk(OFS_MOT + 8'h10, 32'h0000_0020);
      apb(1'b0, 8'h30, 32'h0);
      chk("unmapped error", er, 1'b1);
      $display("test registers done");
      for (int b = 0; b < 7; b++) begin
         want[2] <= 7'(1 << (6 - b));
         repeat (5) @(posedge pclk);
         rchk(OFS_IO + 8'h08, 32'(1 << b));
      end
      $display("test io done");
      pulse(19'h00004);
      rchk(OFS_MOT + 8'h10, 32'h0001_0020);
      pulse(19'h00003);
      rchk(OFS_MOT + 8'h10, 32'h000d_0020);
      pulse(19'h00010);
      rchk(OFS_MOT + 8'h10, 32'h0000_0000);
      pulse(19'h00008);
      rchk(OFS_MOT + 8'h10, 32'h0000_0020);
      $display("test events done");
      kin[1] <= 19'h7ffe0;
      want[1] <= 7'h09;
      qty[5].cmd_pos <= -32'sd7;
      qty[5].fbk_pos <= 32'sd100;
      qty[6].fbk_pos <= 32'sd40;
      qty[5].cmd_vel <= 32'sd8;
      qty[5].fbk_vel <= -32'sd2;
      qty[5].ctrl_mv <= 32'sd1500;
      qty[5].err_pos <= -32'sd3;
      qty[5].raw_enc <= 32'h0000_1234;
      path_vel[1] <= 64'h4059_0000_0000_0000;
      path_acc[0] <= 64'h408f_4000_0000_0000;
      unit_vel[1] <= 64'h4024_0000_0000_0000;
      apb(1'b1, OFS_GANTRY, 32'h0000_0065);
      rchk(OFS_MOT + 8'h04, 32'h1002_8c5f);
      rchk(OFS_IO + 8'h04, 32'h0000_18c8);
      smp(5'd5, 3'd1, 64'h1002_8c5f);
      smp(5'd4, 3'd1, 64'h18c8);
      smp(5'd6, 3'd1, 64'h1);
      smp(5'd7, 3'd1, 64'h1);
      smp(5'd8, 3'd1, 64'h1);
      smp(5'd9, 3'd1, 64'h1);
      smp(5'd10, 3'd1, 64'h0);
      smp(5'd10, 3'd0, 64'h1);
      smp(5'd11, 3'd1, 64'h1);
      smp(5'd12, 3'd1, 64'h1);
      smp(5'd12, 3'd0, 64'h0);
      smp(5'd13, 3'd5, 64'd1500);
      smp(5'd21, 3'd5, 64'h4097_7000_0000_0000);
      smp(5'd17, 3'd5, 64'hc01c_0000_0000_0000);
      smp(5'd14, 3'd5, 64'd60);
      smp(5'd15, 3'd5, 64'h1234);
      smp(5'd16, 3'd5, 64'hffff_ffff_ffff_fffd);
      smp(5'd1, 3'd5, 64'd100);
      smp(5'd18, 3'd5, 64'h4059_0000_0000_0000);
      smp(5'd2, 3'd5, 64'd8);
      smp(5'd19, 3'd5, 64'h4020_0000_0000_0000);
      smp(5'd3, 3'd5, 64'hffff_ffff_ffff_fffe);
      smp(5'd20, 3'd5, 64'hc000_0000_0000_0000);
      smp(5'd22, 3'd5, 64'hc008_0000_0000_0000);
      smp(5'd24, 3'd1, 64'h4059_0000_0000_0000);
      smp(5'd25, 3'd0, 64'h408f_4000_0000_0000);
      smp(5'd23, 3'd1, 64'h4024_0000_0000_0000);
      apb(1'b1, OFS_PULSE, 32'h0000_0020);
      smp(5'd16, 3'd5, 64'h0);
      smp(5'd20, 3'd5, 64'h0);
      apb(1'b0, OFS_STAT, 32'h0);
      chk("invalid flag", rd[S_INV], 1'b1);
      smp(5'd0, 3'd5, 64'hffff_ffff_ffff_fff9);
      $display("test samples done");
      report_and_stop();
   end
endmodule : axs_sampler_bench
bind axs_sampler axs_chk #(.KERNEL_CYCLES(KERNEL_CYCLES)) i_axs_chk (.pclk(pclk),
   .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .sample_valid(sample_valid),
   .sample_data(sample_data));

// *** inc/axs_pkg.sv ***
package axs_pkg;
   // sizes
   localparam int NAX = 8;
   localparam int AXW = 3;
   localparam int QW = 32;
   localparam int DW = 64;
   localparam int NSYNC = 2;

   // timing
   localparam int CLK_HZ = 50_000_000;
   localparam int KERNEL_PERIOD_US = 1000;
   localparam int LOOP_PERIOD_US = 250;
   localparam int KERNEL_CYC = CLK_HZ / 1_000_000 * KERNEL_PERIOD_US;
   localparam int LOOP_CYC = CLK_HZ / 1_000_000 * LOOP_PERIOD_US;
   localparam logic [15:0] LOOP_CYC_RST = 16'(LOOP_CYC);

   // register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_LOOP = 8'h04;
   localparam logic [7:0] OFS_PULSE = 8'h08;
   localparam logic [7:0] OFS_GANTRY = 8'h0c;
   localparam logic [7:0] OFS_SLO = 8'h10;
   localparam logic [7:0] OFS_SHI = 8'h14;
   localparam logic [7:0] OFS_STAT = 8'h18;
   localparam logic [7:0] OFS_IO = 8'h40;
   localparam logic [7:0] OFS_MOT = 8'h60;

   // control fields
   localparam int C_EN = 0;
   localparam int C_SRC_LO = 4;
   localparam int C_IDX_LO = 12;
   localparam int G_MST_LO = 0;
   localparam int G_SLV_LO = 4;
   localparam int S_RDY = 0;
   localparam int S_OVR = 1;
   localparam int S_INV = 2;
   localparam int S_CNT_LO = 16;

   // io word bits
   localparam int IO_ALM = 0;
   localparam int IO_PLIM = 1;
   localparam int IO_NLIM = 2;
   localparam int IO_HOME = 3;
   localparam int IO_ESTOP = 4;
   localparam int IO_INDEX = 5;
   localparam int IO_INPOS = 6;
   localparam int IO_SERVO_ON_OUT = 7;
   localparam int IO_SPLIM = 11;
   localparam int IO_SNLIM = 12;

   // motion word bits
   localparam int MS_COMMAND_STOPPED = 0;
   localparam int MS_VMAX = 1;
   localparam int MS_ACC = 2;
   localparam int MS_DEC = 3;
   localparam int MS_DIR = 4;
   localparam int MS_DONE = 5;
   localparam int MS_HOME = 6;
   localparam int MS_WAIT = 10;
   localparam int MS_TBL = 11;
   localparam int MS_JOG = 15;
   localparam int MS_ABNORMAL_STOP = 16;
   localparam int MS_BLD = 17;
   localparam int MS_PRE = 18;
   localparam int MS_POST = 19;
   localparam int MS_GEAR = 28;

   // double-precision layout
   localparam logic [10:0] F64_BIAS = 11'h3ff;
   localparam int F64_MANT = 52;

   typedef enum logic [4:0] {
      SRC_CMD_POS, SRC_FBK_POS, SRC_CMD_VEL, SRC_FBK_VEL, SRC_IO, SRC_MOTION,
      SRC_ACC_FLAG, SRC_CRUISE_FLAG, SRC_DEC_FLAG, SRC_STOP_FLAG, SRC_DONE_FLAG,
      SRC_INPOS_FLAG, SRC_HOME_FLAG, SRC_CTRL_MV, SRC_GANTRY, SRC_RAW_ENC,
      SRC_ERR_POS, SRC_CMD_POS_F, SRC_FBK_POS_F, SRC_CMD_VEL_F, SRC_FBK_VEL_F,
      SRC_CTRL_MV_F, SRC_ERR_POS_F, SRC_UNIT_VEL_F, SRC_PATH_VEL_F, SRC_PATH_ACC_F
   } axs_src_e;

   // per-axis input pins
   typedef struct packed {
      logic alarm;
      logic pos_lim;
      logic neg_lim;
      logic home;
      logic estop;
      logic index;
      logic inpos;
   } axs_pin_s;

   // per-axis kernel state, same clock
   typedef struct packed {
      logic command_stopped;
      logic at_max_velocity;
      logic accelerating;
      logic decelerating;
      logic direction;
      logic homing_active;
      logic waiting_trigger;
      logic table_moving;
      logic jogging;
      logic blending_active;
      logic geared_slave;
      logic servo_on_out;
      logic soft_positive_limit_hit;
      logic soft_negative_limit_hit;
      logic move_start;
      logic normal_stop;
      logic abnormal_stop_evt;
      logic pre_distance_event;
      logic post_distance_event;
   } axs_kin_s;

   // per-axis quantities, signed pulses, pulse/s or mV
   typedef struct packed {
      logic signed [QW-1:0] cmd_pos;
      logic signed [QW-1:0] fbk_pos;
      logic signed [QW-1:0] cmd_vel;
      logic signed [QW-1:0] fbk_vel;
      logic signed [QW-1:0] ctrl_mv;
      logic signed [QW-1:0] err_pos;
      logic signed [QW-1:0] raw_enc;
   } axs_qty_s;
endpackage : axs_pkg

// *** rtl/axs_sampler.sv ***
// Design decisions made here: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
// Overview of operation
// - every 1 ms capture the selected source and hand it over as one sample
// - kernel quantities refresh every 1 ms, loop quantities on adjustable 250 us period
// - axis in pulse mode: closed-loop sources invalid, sample reads zero
// - any source selectable for axis 0..7; positions are signed pulse counts
// - position, velocity, voltage and error also offered as doubles
// - path velocity and acceleration samples for table 0 or 1
// - power-control composed velocity sample for unit 0 or 1
// - control command sample in millivolts, integer and double
// - gantry sample: master minus slave feedback position in pulses
// - raw encoder position sample kept apart from processed feedback
// - io word bits 0..6 hold input states, bit 7 servo-on output
// - io bits 11 and 12 show soft positive and negative limit hits
// - motion word places the motion flags at their fixed bit positions
// - acceleration sample is 1 only in acceleration section
// - constant-speed sample is 1 only at maximum velocity
// - deceleration sample is 1 only in deceleration section
// - command-stop sample is 1 once the command stopped
// - completion sample is 1 once the movement completed
// - in-position sample follows the drive in-position input
// - home sample follows the home sensor input
// - abnormal-stop flag set by abnormal stop, cleared on motion start or normal stop
// - pre and post distance flags set by event, cleared on motion start
// - table moving clears the done and abnormal-stop flags
module axs_sampler
   import axs_pkg::*;
#(
   parameter int KERNEL_CYCLES = KERNEL_CYC
) (
   // clock, reset, enable
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // machine pins, asynchronous
   input wire axs_pin_s [NAX-1:0] pins,
   // motion kernel, same clock
   input wire axs_kin_s [NAX-1:0] kin,
   input wire axs_qty_s [NAX-1:0] qty,
   input wire logic [1:0][DW-1:0] path_vel,
   input wire logic [1:0][DW-1:0] path_acc,
   input wire logic [1:0][DW-1:0] unit_vel,
   // sample stream
   output logic sample_valid,
   output logic [DW-1:0] sample_data
);

   localparam int PW = $bits(axs_pin_s);

   function automatic logic [DW-1:0] to_f64(input logic signed [QW-1:0] v);
      logic [QW-1:0] mag;
      logic [DW-1:0] r;
      int msb;
      mag = v[QW-1] ? 32'(-v) : 32'(v);
      msb = 0;
      r = '0;
      for (int i = 0; i < QW; i++) begin
         if (mag[i]) begin
            msb = i;
         end
      end
      if (mag != '0) begin
         r[DW-1] = v[QW-1];
         r[DW-2:F64_MANT] = F64_BIAS + 11'(msb);
         r[F64_MANT-1:0] = 52'({20'h0, mag} << (F64_MANT - msb));
      end
      return r;
   endfunction : to_f64

   // pin synchroniser
   logic [NAX*PW-1:0] pin_meta;
   logic [NAX*PW-1:0] pin_sync;
   axs_pin_s [NAX-1:0] pin_s;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_meta <= '0;
         pin_sync <= '0;
      end else if (ce) begin
         pin_meta <= pins;
         pin_sync <= pin_meta;
      end
   end
   assign pin_s = pin_sync;

   // registers
   logic samp_en;
   axs_src_e samp_src;
   logic [AXW-1:0] samp_idx;
   logic [15:0] loop_period;
   logic [NAX-1:0] pulse_mode;
   logic [AXW-1:0] gantry_master;
   logic [AXW-1:0] gantry_slave;
   logic samp_ready;
   logic samp_overrun;
   logic samp_invalid;
   logic [15:0] samp_count;

   // per-axis words
   logic [15:0] io_word [NAX];
   logic [31:0] mot_word [NAX];
   axs_qty_s q_hold [NAX];

   // ticks
   logic [15:0] kern_cnt;
   logic [15:0] loop_cnt;
   logic kern_tick;
   logic loop_tick;

   assign kern_tick = kern_cnt == 16'(KERNEL_CYCLES - 1);
   assign loop_tick = (loop_cnt >= loop_period - 16'h0001) || (loop_period == 16'h0000);

   // period change takes effect at once; a count already at or past the new period wraps in the next cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         kern_cnt <= '0;
         loop_cnt <= '0;
      end else if (ce) begin
         kern_cnt <= kern_tick ? '0 : kern_cnt + 16'h0001;
         loop_cnt <= loop_tick ? '0 : loop_cnt + 16'h0001;
      end
   end

   // per-axis status and held quantities
   for (genvar a = 0; a < NAX; a++) begin : g_axis
      logic done_f;
      logic abnormal_stop_f;
      logic pre_f;
      logic post_f;

      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            done_f <= 1'b1;
            abnormal_stop_f <= 1'b0;
            pre_f <= 1'b0;
            post_f <= 1'b0;
         end else if (ce) begin
            if (kin[a].table_moving) begin
               done_f <= 1'b0;
               abnormal_stop_f <= 1'b0;
            end else begin
               if (kin[a].normal_stop || kin[a].abnormal_stop_evt) begin
                  done_f <= 1'b1;
               end else if (kin[a].move_start) begin
                  done_f <= 1'b0;
               end
               if (kin[a].abnormal_stop_evt) begin
                  abnormal_stop_f <= 1'b1;
               end else if (kin[a].move_start || kin[a].normal_stop) begin
                  abnormal_stop_f <= 1'b0;
               end
            end
            // event beats a start in the same cycle
            if (kin[a].pre_distance_event) begin
               pre_f <= 1'b1;
            end else if (kin[a].move_start) begin
               pre_f <= 1'b0;
            end
            if (kin[a].post_distance_event) begin
               post_f <= 1'b1;
            end else if (kin[a].move_start) begin
               post_f <= 1'b0;
            end
         end
      end

      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            io_word[a] <= '0;
            mot_word[a] <= '0;
         end else if (ce) begin
            io_word[a] <= '0;
            io_word[a][IO_ALM] <= pin_s[a].alarm;
            io_word[a][IO_PLIM] <= pin_s[a].pos_lim;
            io_word[a][IO_NLIM] <= pin_s[a].neg_lim;
            io_word[a][IO_HOME] <= pin_s[a].home;
            io_word[a][IO_ESTOP] <= pin_s[a].estop;
            io_word[a][IO_INDEX] <= pin_s[a].index;
            io_word[a][IO_INPOS] <= pin_s[a].inpos;
            io_word[a][IO_SERVO_ON_OUT] <= kin[a].servo_on_out;
            io_word[a][IO_SPLIM] <= kin[a].soft_positive_limit_hit;
            io_word[a][IO_SNLIM] <= kin[a].soft_negative_limit_hit;
            mot_word[a] <= '0;
            mot_word[a][MS_COMMAND_STOPPED] <= kin[a].command_stopped;
            mot_word[a][MS_VMAX] <= kin[a].at_max_velocity;
            mot_word[a][MS_ACC] <= kin[a].accelerating;
            mot_word[a][MS_DEC] <= kin[a].decelerating;
            mot_word[a][MS_DIR] <= kin[a].direction;
            mot_word[a][MS_DONE] <= done_f;
            mot_word[a][MS_HOME] <= kin[a].homing_active;
            mot_word[a][MS_WAIT] <= kin[a].waiting_trigger;
            mot_word[a][MS_TBL] <= kin[a].table_moving;
            mot_word[a][MS_JOG] <= kin[a].jogging;
            mot_word[a][MS_ABNORMAL_STOP] <= abnormal_stop_f;
            mot_word[a][MS_BLD] <= kin[a].blending_active;
            mot_word[a][MS_PRE] <= pre_f;
            mot_word[a][MS_POST] <= post_f;
            mot_word[a][MS_GEAR] <= kin[a].geared_slave;
         end
      end

      // kernel set on the 1 ms tick, loop set on the loop tick
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            q_hold[a] <= '0;
         end else if (ce) begin
            if (kern_tick) begin
               q_hold[a].cmd_pos <= qty[a].cmd_pos;
               q_hold[a].fbk_pos <= qty[a].fbk_pos;
               q_hold[a].cmd_vel <= qty[a].cmd_vel;
               q_hold[a].raw_enc <= qty[a].raw_enc;
            end
            if (loop_tick) begin
               q_hold[a].fbk_vel <= qty[a].fbk_vel;
               q_hold[a].ctrl_mv <= qty[a].ctrl_mv;
               q_hold[a].err_pos <= qty[a].err_pos;
            end
         end
      end
   end

   // source selection
   axs_qty_s q_sel;
   logic signed [QW-1:0] gantry_diff;
   logic [DW-1:0] next_sample;
   logic next_invalid;
   logic is_loop_src;

   assign q_sel = q_hold[samp_idx];
   assign gantry_diff = q_hold[gantry_master].fbk_pos - q_hold[gantry_slave].fbk_pos;

   always_comb begin
      next_sample = '0;
      unique case (samp_src)
         SRC_CMD_POS: next_sample = DW'(q_sel.cmd_pos);
         SRC_FBK_POS: next_sample = DW'(q_sel.fbk_pos);
         SRC_CMD_VEL: next_sample = DW'(q_sel.cmd_vel);
         SRC_FBK_VEL: next_sample = DW'(q_sel.fbk_vel);
         SRC_IO: next_sample = DW'(io_word[samp_idx]);
         SRC_MOTION: next_sample = DW'(mot_word[samp_idx]);
         SRC_ACC_FLAG: next_sample = DW'(mot_word[samp_idx][MS_ACC]);
         SRC_CRUISE_FLAG: next_sample = DW'(mot_word[samp_idx][MS_VMAX]);
         SRC_DEC_FLAG: next_sample = DW'(mot_word[samp_idx][MS_DEC]);
         SRC_STOP_FLAG: next_sample = DW'(mot_word[samp_idx][MS_COMMAND_STOPPED]);
         SRC_DONE_FLAG: next_sample = DW'(mot_word[samp_idx][MS_DONE]);
         SRC_INPOS_FLAG: next_sample = DW'(io_word[samp_idx][IO_INPOS]);
         SRC_HOME_FLAG: next_sample = DW'(io_word[samp_idx][IO_HOME]);
         SRC_CTRL_MV: next_sample = DW'(q_sel.ctrl_mv);
         SRC_GANTRY: next_sample = DW'(gantry_diff);
         SRC_RAW_ENC: next_sample = DW'(q_sel.raw_enc);
         SRC_ERR_POS: next_sample = DW'(q_sel.err_pos);
         SRC_CMD_POS_F: next_sample = to_f64(q_sel.cmd_pos);
         SRC_FBK_POS_F: next_sample = to_f64(q_sel.fbk_pos);
         SRC_CMD_VEL_F: next_sample = to_f64(q_sel.cmd_vel);
         SRC_FBK_VEL_F: next_sample = to_f64(q_sel.fbk_vel);
         SRC_CTRL_MV_F: next_sample = to_f64(q_sel.ctrl_mv);
         SRC_ERR_POS_F: next_sample = to_f64(q_sel.err_pos);
         SRC_UNIT_VEL_F: next_sample = unit_vel[samp_idx[0]];
         SRC_PATH_VEL_F: next_sample = path_vel[samp_idx[0]];
         SRC_PATH_ACC_F: next_sample = path_acc[samp_idx[0]];
         default: next_sample = '0;
      endcase
      // signed values widen with sign
      if (samp_src inside {SRC_CMD_POS, SRC_FBK_POS, SRC_CMD_VEL, SRC_FBK_VEL, SRC_CTRL_MV,
            SRC_GANTRY, SRC_RAW_ENC, SRC_ERR_POS}) begin
         next_sample = {{QW{next_sample[QW-1]}}, next_sample[QW-1:0]};
      end
      is_loop_src = samp_src inside {SRC_FBK_VEL, SRC_CTRL_MV, SRC_ERR_POS, SRC_FBK_VEL_F,
         SRC_CTRL_MV_F, SRC_ERR_POS_F};
      next_invalid = is_loop_src && pulse_mode[samp_idx];
      if (next_invalid) begin
         next_sample = '0;
      end
   end

   // apb handshake: one wait state, pready and prdata registered
   logic acc_done;
   logic wr_en;
   logic rd_hi;
   logic [31:0] next_rdata;
   logic next_err;

   assign acc_done = psel && penable && pready;
   assign wr_en = acc_done && pwrite;
   assign rd_hi = acc_done && !pwrite && paddr == OFS_SHI;

   always_comb begin
      next_rdata = '0;
      next_err = 1'b0;
      if (paddr >= OFS_IO && paddr < OFS_IO + 8'(4 * NAX) && paddr[1:0] == 2'b00) begin
         next_rdata = {16'h0000, io_word[paddr[AXW+1:2]]};
      end else if (paddr >= OFS_MOT && paddr < OFS_MOT + 8'(4 * NAX) && paddr[1:0] == 2'b00) begin
         next_rdata = mot_word[paddr[AXW+1:2]];
      end else begin
         unique case (paddr)
            OFS_CTRL: begin
               next_rdata[C_EN] = samp_en;
               next_rdata[C_SRC_LO +: 5] = samp_src;
               next_rdata[C_IDX_LO +: AXW] = samp_idx;
            end
            OFS_LOOP: next_rdata = {16'h0000, loop_period};
            OFS_PULSE: next_rdata = 32'(pulse_mode);
            OFS_GANTRY: begin
               next_rdata[G_MST_LO +: AXW] = gantry_master;
               next_rdata[G_SLV_LO +: AXW] = gantry_slave;
            end
            OFS_SLO: next_rdata = sample_data[31:0];
            OFS_SHI: next_rdata = sample_data[63:32];
            OFS_STAT: begin
               next_rdata[S_RDY] = samp_ready;
               next_rdata[S_OVR] = samp_overrun;
               next_rdata[S_INV] = samp_invalid;
               next_rdata[S_CNT_LO +: 16] = samp_count;
            end
            default: next_err = 1'b1;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         prdata <= '0;
         pslverr <= 1'b0;
      end else if (ce) begin
         pready <= psel && penable && !pready;
         prdata <= (psel && penable && !pready && !pwrite) ? next_rdata : '0;
         pslverr <= psel && penable && !pready && next_err;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         samp_en <= 1'b0;
         samp_src <= SRC_CMD_POS;
         samp_idx <= '0;
         loop_period <= LOOP_CYC_RST;
         pulse_mode <= '0;
         gantry_master <= '0;
         gantry_slave <= '0;
      end else if (ce && wr_en) begin
         unique case (paddr)
            OFS_CTRL: begin
               samp_en <= pwdata[C_EN];
               samp_src <= axs_src_e'(pwdata[C_SRC_LO +: 5]);
               samp_idx <= pwdata[C_IDX_LO +: AXW];
            end
            OFS_LOOP: loop_period <= pwdata[15:0];
            OFS_PULSE: pulse_mode <= pwdata[NAX-1:0];
            OFS_GANTRY: begin
               gantry_master <= pwdata[G_MST_LO +: AXW];
               gantry_slave <= pwdata[G_SLV_LO +: AXW];
            end
            default: ;
         endcase
      end
   end

   // capture; a tick in the clearing read cycle still flags ready
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sample_valid <= 1'b0;
         sample_data <= '0;
         samp_ready <= 1'b0;
         samp_overrun <= 1'b0;
         samp_invalid <= 1'b0;
         samp_count <= '0;
      end else if (ce) begin
         sample_valid <= samp_en && kern_tick;
         if (samp_en && kern_tick) begin
            sample_data <= next_sample;
            samp_invalid <= next_invalid;
            samp_count <= samp_count + 16'h0001;
            samp_ready <= 1'b1;
            samp_overrun <= !rd_hi && (samp_overrun || samp_ready);
         end else if (rd_hi) begin
            samp_ready <= 1'b0;
            samp_overrun <= 1'b0;
         end
      end
   end

endmodule : axs_sampler
